//--- bench/ebs_checker.sv
// Port-level assertions for the external bus strobe steering block
`timescale 1ns/1ps
`include "ebs_defs.vh"
module ebs_checker (
  input wire       MCLK,
  input wire       RESET,
  input wire       CPU_READY,
  input wire       CPU_WAIT,
  input wire       IOCHRDY_IN,
  input wire       CORE_POWER_GOOD_IN,
  input wire       SYSTEM_POWER_GOOD_IN,
  input wire       D_OE_N,
  input wire [2:0] TARGET_CLASS,
  input wire       EXT_IO_READ_STROBE_N,
  input wire       EXT_IO_WRITE_STROBE_N,
  input wire       EXT_MEM_READ_STROBE_N,
  input wire       EXT_MEM_WRITE_STROBE_N,
  input wire [1:0] BOOT_ROM_CHIP_ENABLES_N,
  input wire       EXP_BUS_CLK,
  input wire       SYSTEM_RESET_OUT_N,
  input wire       CORE_RESET,
  input wire       CLOCK_RESTART
);
  reg [7:0] quiet_reg; // Cycles since any reset source was last active
  // Quiet counter saturates so a long idle never wraps back below the stretch
  always @(posedge MCLK) begin
    if (CORE_RESET || CLOCK_RESTART) begin
      quiet_reg <= 8'h00;
    end else if (quiet_reg != 8'hff) begin
      quiet_reg <= quiet_reg + 8'h01;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET || CORE_RESET);
  a_ram_no_mrd: assert property (!EXT_MEM_READ_STROBE_N |-> TARGET_CLASS != `EBS_TGT_RAM)
    else $error("memory read strobe in a RAM cycle");
  a_mwr_exp_only: assert property (!EXT_MEM_WRITE_STROBE_N |->
    TARGET_CLASS == `EBS_TGT_EXPMEM)
    else $error("memory write strobe outside expansion memory");
  a_ior_io_width: assert property ($fell(EXT_IO_READ_STROBE_N) |->
    (!EXT_IO_READ_STROBE_N && TARGET_CLASS == `EBS_TGT_IO)[*4])
    else $error("I/O read strobe short or on a non-I/O cycle");
  a_iow_data_valid: assert property (!EXT_IO_WRITE_STROBE_N |->
    !D_OE_N && TARGET_CLASS == `EBS_TGT_IO)
    else $error("I/O write strobe without driven data");
  a_romce_rom_only: assert property (BOOT_ROM_CHIP_ENABLES_N != 2'h3 |->
    TARGET_CLASS == `EBS_TGT_ROM)
    else $error("ROM enable on a non-ROM cycle");
  a_ready_waits: assert property ((!IOCHRDY_IN && CPU_WAIT)[*4] |-> !CPU_READY)
    else $error("cycle ended while channel not ready");
  a_core_rst_out: assert property (disable iff (1'b0) CORE_RESET |=> !SYSTEM_RESET_OUT_N)
    else $error("reset output high during core reset");
  a_pg_core_rst: assert property (disable iff (RESET)
    $fell(CORE_POWER_GOOD_IN) |-> ##[1:3] CORE_RESET)
    else $error("core power-good loss not seen");
  a_pg_sys_rst: assert property (disable iff (RESET)
    $fell(SYSTEM_POWER_GOOD_IN) |-> ##[1:3] CLOCK_RESTART ##[0:3] !SYSTEM_RESET_OUT_N)
    else $error("system power-good loss not seen");
  a_rst_stretch: assert property ($rose(SYSTEM_RESET_OUT_N) |-> quiet_reg >= 8'h0f)
    else $error("reset output released too early");
  a_xclk_half: assert property (disable iff (RESET || CORE_RESET || CLOCK_RESTART)
    $rose(EXP_BUS_CLK) |=> EXP_BUS_CLK[*5] ##1 !EXP_BUS_CLK)
    else $error("expansion clock high time wrong");
endmodule
bind ebs_top ebs_checker u_chk (.*);

//--- bench/ebs_periph.sv
// Behavioural ISA peripheral and ROM on the far side of the strobes
`timescale 1ns/1ps
module ebs_periph (
  input  wire        clk,
  input  wire [23:0] addr,
  input  wire [5:0]  strb_n,         // {ce1, ce0, mem wr, mem rd, io wr, io rd}, low active
  input  wire        wide_io,        // I/O target answers on both lanes
  input  wire        wide_mem,       // Memory target answers on both lanes
  input  wire [7:0]  slow,           // Not-ready cycles per access
  output reg  [15:0] d_in = 16'h0000,
  output wire        rdy,
  output wire        io_cs16_n,
  output wire        mem_cs16_n
);
  wire       act  = ~&strb_n;                               // Any access active
  wire       rd   = ~&{strb_n[5:4], strb_n[2], strb_n[0]};  // Read kind of access
  wire       wide = strb_n[0] ? wide_mem : wide_io;         // Lane width of target
  reg        act_reg = 1'b0;
  reg  [7:0] cnt_reg = 8'h00;
  // Width flags are open-collector, so they rest high unless word capable
  assign io_cs16_n  = ~wide_io;
  assign mem_cs16_n = ~wide_mem;
  // Ready drops in the first strobe cycle, else the sync flops would see it late
  assign rdy = (cnt_reg == 8'h00) && !(act && !act_reg && slow != 8'h00);
  // Stretch count, then read data; released lanes toggle so stale values never match
  always @(posedge clk) begin
    act_reg <= act;
    if (act && !act_reg) begin
      cnt_reg <= slow;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
    if (rd) begin
      d_in <= {wide ? 8'hc3 : ~d_in[15:8], addr[7:0]};
    end else begin
      d_in <= ~d_in;
    end
  end
endmodule

//--- bench/ebs_top_tb.sv
// Self-checking bench for the external bus strobe steering block
`timescale 1ns/1ps
`include "ebs_defs.vh"
module ebs_top_tb;
  logic        MCLK = 1'b0, RESET = 1'b1, CPU_REQ = 1'b0, CPU_IO = 1'b0, CPU_WR = 1'b0;
  logic        CPU_WORD = 1'b0, INT_NOT_READY = 1'b0, ROM_WIDTH_STRAP = 1'b1;
  logic        CORE_POWER_GOOD_IN = 1'b1, SYSTEM_POWER_GOOD_IN = 1'b1;
  logic [23:0] CPU_ADDR = 24'h000000;
  logic [15:0] CPU_WDATA = 16'h5aa5;
  logic [7:0]  cfg = 8'h00;                // {card, sram, ram, rd-oe, hit, wr-sup, rd-sup, shadow}
  logic [63:0] win0 = 64'h0, win1 = 64'h0; // Window maps to ROM banks
  logic        io_wide = 1'b1, mem_wide = 1'b1;
  logic [7:0]  slow = 8'h00;
  logic [6:0]  seen;                       // {bhe, ce1, ce0, mwr, mrd, iow, ior} seen low
  logic [1:0]  pulses;                     // Separate strobe bursts in one cycle
  logic [15:0] wd_seen;                    // Last data bus value under a write strobe
  int          len, cyc, int_hold = 0, error_cnt = 0, checks = 0;
  wire  [15:0] CPU_RDATA, D_IN, d_out;
  wire  [23:0] a_out;
  wire  [2:0]  TARGET_CLASS;
  wire  [1:0]  ce_n;
  wire         CPU_READY, IOCHRDY_IN, IO_CS16_N, MEM_CS16_N, ior_n, iow_n, mrd_n, mwr_n;
  wire         bhe_n, rst_out_n, core_rst, clk_restart;
  wire  [5:0]  strb_n = {ce_n, mwr_n, mrd_n, iow_n, ior_n};
  // 100 MHz system clock
  always #5 MCLK = ~MCLK;
  ebs_top u_dut (
    .MCLK(MCLK), .RESET(RESET), .CPU_REQ(CPU_REQ), .CPU_IO(CPU_IO), .CPU_WR(CPU_WR),
    .CPU_WORD(CPU_WORD), .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA),
    .CPU_READY(CPU_READY), .CPU_WAIT(), .INT_NOT_READY(INT_NOT_READY), .BIOS_SHADOWED(cfg[0]),
    .IORD_SUPPRESS_INT(cfg[1]), .IOWR_SUPPRESS_INT(cfg[2]), .INT_PERIPH_HIT(cfg[3]),
    .MEM_RD_AS_ROM_OE(cfg[4]), .RAM_HIT(cfg[5]), .SRAM_HIT(cfg[6]), .CARD_HIT(cfg[7]),
    .WIN_BANK_ZERO_MAP(win0), .WIN_BANK_ONE_MAP(win1), .IOCHRDY_IN(IOCHRDY_IN),
    .ROM_WIDTH_STRAP(ROM_WIDTH_STRAP), .IO_CS16_N(IO_CS16_N), .MEM_CS16_N(MEM_CS16_N),
    .CORE_POWER_GOOD_IN(CORE_POWER_GOOD_IN), .SYSTEM_POWER_GOOD_IN(SYSTEM_POWER_GOOD_IN),
    .A_OUT(a_out), .D_OUT(d_out), .D_OE_N(), .D_IN(D_IN), .TARGET_CLASS(TARGET_CLASS),
    .EXT_IO_READ_STROBE_N(ior_n), .EXT_IO_WRITE_STROBE_N(iow_n), .EXT_MEM_READ_STROBE_N(mrd_n),
    .EXT_MEM_WRITE_STROBE_N(mwr_n), .BOOT_ROM_CHIP_ENABLES_N(ce_n), .BYTE_HIGH_ENABLE_N(bhe_n),
    .EXP_BUS_CLK(), .SYSTEM_RESET_OUT_N(rst_out_n), .CORE_RESET(core_rst),
    .CLOCK_RESTART(clk_restart)
  );
  ebs_periph u_periph (
    .clk(MCLK), .addr(a_out), .strb_n(strb_n), .wide_io(io_wide), .wide_mem(mem_wide),
    .slow(slow), .d_in(D_IN), .rdy(IOCHRDY_IN), .io_cs16_n(IO_CS16_N), .mem_cs16_n(MEM_CS16_N)
  );
  // Verdict and end of run; also reached when a bounded wait runs out
  task automatic tally_and_finish;
    begin
      $display("checks=%0d mismatches=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // Value compare, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        error_cnt++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One CPU cycle; the high-enable bit only counts for word cycles
  task automatic run(input logic io, wr, wd, input logic [23:0] ad, input logic [2:0] cls,
                     input logic [6:0] sn, input logic [1:0] pl);
    logic pa;
    begin
      {CPU_IO, CPU_WR, CPU_WORD, CPU_ADDR, CPU_REQ} = {io, wr, wd, ad, 1'b1};
      {seen, pulses, pa, len, wd_seen} = '0;
      INT_NOT_READY = (int_hold > 0);
      @(negedge MCLK);
      CPU_REQ = 1'b0;
      while (len < 500 && CPU_READY !== 1'b1) begin
        @(negedge MCLK);
        len++;
        INT_NOT_READY = (len < int_hold);
        seen = seen | {~bhe_n, ~strb_n};
        if (!iow_n || !mwr_n) wd_seen = d_out;
        if (~&strb_n && !pa) pulses = pulses + 2'h1;
        pa = ~&strb_n;
      end
      INT_NOT_READY = 1'b0;
      if (CPU_READY !== 1'b1) begin
        error_cnt++;
        tally_and_finish();
      end
      chk(16'(TARGET_CLASS), 16'(cls));
      chk(16'(seen & {wd, 6'h3f}), 16'(sn & {wd, 6'h3f}));
      chk(16'(pulses), 16'(pl));
      @(negedge MCLK);
    end
  endtask
  // Bounded wait for the reset output to release, counting cycles
  task automatic wait_rst;
    begin
      for (cyc = 0; cyc < 200 && rst_out_n !== 1'b1; cyc++) @(negedge MCLK);
      if (cyc == 200) begin
        error_cnt++;
        tally_and_finish();
      end
    end
  endtask
  initial begin
    repeat (16) @(negedge MCLK);
    RESET = 1'b0;
    wait_rst();
    chk(16'(strb_n), 16'h003f);
    repeat (3) @(negedge MCLK);
    run(1, 0, 0, 24'h000300, `EBS_TGT_IO, 7'h01, 2'h1);
    chk(16'(len < 30), 16'h1);
    run(1, 0, 1, 24'h000320, `EBS_TGT_IO, 7'h41, 2'h1);
    chk(CPU_RDATA, 16'hc320);
    run(1, 1, 1, 24'h000330, `EBS_TGT_IO, 7'h42, 2'h1);
    chk(wd_seen, 16'h5aa5);
    io_wide = 1'b0;
    repeat (3) @(negedge MCLK);
    run(1, 0, 1, 24'h000310, `EBS_TGT_IO, 7'h01, 2'h2);
    chk(CPU_RDATA, 16'h1110);
    $display("test io cycles done");
    cfg = 8'h0e;
    run(1, 0, 0, 24'h000300, `EBS_TGT_IO, 7'h00, 2'h0);
    run(1, 1, 0, 24'h000300, `EBS_TGT_IO, 7'h00, 2'h0);
    cfg = 8'h08;
    run(1, 1, 0, 24'h000300, `EBS_TGT_IO, 7'h02, 2'h1);
    $display("test suppression done");
    {cfg, mem_wide} = 9'h0;
    repeat (3) @(negedge MCLK);
    run(0, 0, 1, 24'h0f0000, `EBS_TGT_ROM, 7'h10, 2'h2);
    chk(CPU_RDATA, 16'h0100);
    {ROM_WIDTH_STRAP, mem_wide} = 2'b01;
    repeat (3) @(negedge MCLK);
    run(0, 0, 1, 24'h0f0000, `EBS_TGT_ROM, 7'h50, 2'h1);
    chk(CPU_RDATA, 16'hc300);
    cfg = 8'h21;
    run(0, 0, 0, 24'h0f0000, `EBS_TGT_RAM, 7'h00, 2'h0);
    {cfg, win0, win1} = {8'h00, 64'h1 << 48, 64'h1 << 52};
    run(0, 0, 0, 24'h0c0000, `EBS_TGT_ROM, 7'h10, 2'h1);
    run(0, 0, 0, 24'h0d0000, `EBS_TGT_ROM, 7'h20, 2'h1);
    cfg = 8'h10;
    run(0, 0, 0, 24'h0d0000, `EBS_TGT_ROM, 7'h24, 2'h1);
    $display("test rom decode done");
    {cfg, win0, win1} = '0;
    run(0, 1, 1, 24'h200000, `EBS_TGT_EXPMEM, 7'h48, 2'h1);
    run(0, 0, 0, 24'h200020, `EBS_TGT_EXPMEM, 7'h04, 2'h1);
    mem_wide = 1'b0;
    repeat (3) @(negedge MCLK);
    run(0, 1, 1, 24'h200010, `EBS_TGT_EXPMEM, 7'h08, 2'h2);
    chk(wd_seen, 16'h5a5a);
    cfg = 8'h20;
    run(0, 1, 0, 24'h100000, `EBS_TGT_RAM, 7'h00, 2'h0);
    run(0, 0, 0, 24'h100000, `EBS_TGT_RAM, 7'h00, 2'h0);
    $display("test memory strobes done");
    {cfg, slow} = {8'h00, 8'h1e};
    run(1, 0, 0, 24'h000300, `EBS_TGT_IO, 7'h01, 2'h1);
    chk(16'(len > 30), 16'h1);
    slow = 8'h00;
    int_hold = 40;
    run(1, 0, 0, 24'h000300, `EBS_TGT_IO, 7'h01, 2'h1);
    chk(16'(len >= 40), 16'h1);
    int_hold = 0;
    $display("test wait states done");
    CORE_POWER_GOOD_IN = 1'b0;
    repeat (5) @(negedge MCLK);
    chk({14'h0, core_rst, rst_out_n}, 16'h0002);
    CORE_POWER_GOOD_IN = 1'b1;
    wait_rst();
    chk(16'(cyc >= 16), 16'h1);
    SYSTEM_POWER_GOOD_IN = 1'b0;
    repeat (5) @(negedge MCLK);
    chk({14'h0, clk_restart, rst_out_n}, 16'h0002);
    SYSTEM_POWER_GOOD_IN = 1'b1;
    wait_rst();
    chk(16'(cyc >= 16), 16'h1);
    $display("test power good done");
    tally_and_finish();
  end
endmodule

//--- hdl/ebs_clkdiv.v
// Divider producing the expansion bus clock and its enable pulse
`timescale 1ns/1ps
`include "ebs_defs.vh"
module ebs_clkdiv (
  input  wire clk,
  input  wire rst,
  output reg  xclk,
  output wire xclk_rise
);
  // Half period in system clocks; only the low four bits are meaningful
  localparam integer HALF_INT = `EBS_XCLK_HALF;
  localparam [3:0]   HALF     = HALF_INT[3:0];
  reg [3:0] cnt_reg;  // Cycle counter within a half period

  // Toggle the output every half period; rise pulse marks a new bus tick
  always @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      xclk    <= 1'b0;
    end else if (cnt_reg == HALF - 4'h1) begin
      cnt_reg <= 4'h0;
      xclk    <= ~xclk;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign xclk_rise = (cnt_reg == HALF - 4'h1) & ~xclk;
endmodule

//--- hdl/ebs_top.v
// External bus strobe steering: address decode, strobes, sizing, ready, reset
// Notes on behaviour
// - Address bus meaning follows decoded target class
// - External ready ORed with internal; wait states
// - Strap low 16-bit ROM, high 8-bit
// - ROM enable zero for unshadowed boot reads
// - Mapped windows may enable either ROM bank
// - I/O read strobe; optional internal suppression
// - I/O write strobe; optional internal suppression
// - No memory read strobe for RAM; ROM OE option
// - Memory write strobe only for expansion memory
// - Expansion clock output near 8 MHz
// - Core power-good low resets all, asserts reset out
// - System power-good low resets peripherals, restarts clocks
`timescale 1ns/1ps
`include "ebs_defs.vh"
module ebs_top (
  input  wire        MCLK,
  input  wire        RESET,
  // CPU side request
  input  wire        CPU_REQ,          // One-cycle cycle start
  input  wire        CPU_IO,           // 1 = I/O cycle, 0 = memory
  input  wire        CPU_WR,           // 1 = write
  input  wire        CPU_WORD,         // 1 = word transfer
  input  wire [23:0] CPU_ADDR,
  input  wire [15:0] CPU_WDATA,
  output reg  [15:0] CPU_RDATA,
  output wire        CPU_READY,        // Cycle finished this clock
  output wire        CPU_WAIT,         // Wait state inserted
  input  wire        INT_NOT_READY,    // Internal source requesting extension
  // Configuration
  input  wire        BIOS_SHADOWED,
  input  wire        IORD_SUPPRESS_INT,
  input  wire        IOWR_SUPPRESS_INT,
  input  wire        INT_PERIPH_HIT,   // Address is an on-chip peripheral
  input  wire        MEM_RD_AS_ROM_OE, // Memory read strobe drives ROM OE
  input  wire        RAM_HIT,
  input  wire        SRAM_HIT,
  input  wire        CARD_HIT,
  input  wire [63:0] WIN_BANK_ZERO_MAP, // Expanded memory mapping to ROM bank zero
  input  wire [63:0] WIN_BANK_ONE_MAP,  // Expanded memory mapping to ROM bank one
  // Pins
  input  wire        IOCHRDY_IN,
  input  wire        ROM_WIDTH_STRAP,
  input  wire        IO_CS16_N,
  input  wire        MEM_CS16_N,
  input  wire        CORE_POWER_GOOD_IN,
  input  wire        SYSTEM_POWER_GOOD_IN,
  output reg  [23:0] A_OUT,
  output reg  [15:0] D_OUT,
  output reg         D_OE_N,           // Low while driving the data bus
  input  wire [15:0] D_IN,
  output reg  [2:0]  TARGET_CLASS,
  output reg         EXT_IO_READ_STROBE_N,
  output reg         EXT_IO_WRITE_STROBE_N,
  output reg         EXT_MEM_READ_STROBE_N,
  output reg         EXT_MEM_WRITE_STROBE_N,
  output reg  [1:0]  BOOT_ROM_CHIP_ENABLES_N,
  output reg         BYTE_HIGH_ENABLE_N,
  output wire        EXP_BUS_CLK,
  output wire        SYSTEM_RESET_OUT_N,
  output wire        CORE_RESET,       // Resets registers, RTC and processor
  output wire        CLOCK_RESTART
);
  // State codes, one-hot
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_SET  = 4'b0010;
  localparam [3:0] S_STRB = 4'b0100;
  localparam [3:0] S_END  = 4'b1000;

  // Pin synchronisers, two flops each
  reg [5:0] s1_reg;
  reg [5:0] s2_reg;
  always @(posedge MCLK) begin
    s1_reg <= {IOCHRDY_IN, ROM_WIDTH_STRAP, IO_CS16_N, MEM_CS16_N,
               CORE_POWER_GOOD_IN, SYSTEM_POWER_GOOD_IN};
    s2_reg <= s1_reg;
  end
  wire chrdy   = s2_reg[5];
  wire strap   = s2_reg[4];
  wire iocs16n = s2_reg[3];
  wire mcs16n  = s2_reg[2];
  wire core_pg = s2_reg[1];
  wire sys_pg  = s2_reg[0];

  // Reset sources: core power-good resets everything
  wire core_rst = RESET | ~core_pg;
  assign CORE_RESET = core_rst;
  // System power-good restarts the clock divider
  wire clk_rst = core_rst | ~sys_pg;
  assign CLOCK_RESTART = ~sys_pg;

  // Reset output stretched past either power-good dropping
  reg [7:0] rst_cnt_reg;
  always @(posedge MCLK) begin
    if (RESET | ~core_pg | ~sys_pg)
      rst_cnt_reg <= `EBS_RST_STRETCH;
    else if (rst_cnt_reg != 8'h00)
      rst_cnt_reg <= rst_cnt_reg - 8'h01;
  end
  assign SYSTEM_RESET_OUT_N = (rst_cnt_reg == 8'h00);

  // Expansion bus clock; its rise pulse paces strobes
  wire xtick;
  ebs_clkdiv u_div (
    .clk       (MCLK),
    .rst       (clk_rst),
    .xclk      (EXP_BUS_CLK),
    .xclk_rise (xtick)
  );

  // Decode class of the target from address and hit inputs
  function [2:0] decode;
    input        io;
    input [23:0] a;
    input        ram, sram, card, rom_win;
    begin
      if (io)                                    decode = `EBS_TGT_IO;
      else if (ram)                              decode = `EBS_TGT_RAM;
      else if (sram)                             decode = `EBS_TGT_SRAM;
      else if (card)                             decode = `EBS_TGT_CARD;
      else if (rom_win)                          decode = `EBS_TGT_ROM;
      else                                       decode = `EBS_TGT_EXPMEM;
    end
  endfunction

  // Mapping window lookup used for both banks
  function win_hit;
    input [63:0] map;
    input [23:0] a;
    begin
      win_hit = map[a[`EBS_WIN_MSB:`EBS_WIN_LSB]];
    end
  endfunction

  wire boot_seg = (CPU_ADDR[19:16] == `EBS_BOOT_SEG_HI) & ~BIOS_SHADOWED;
  wire w0 = win_hit(WIN_BANK_ZERO_MAP, CPU_ADDR);
  wire w1 = win_hit(WIN_BANK_ONE_MAP, CPU_ADDR);
  wire [2:0] cls = decode(CPU_IO, CPU_ADDR, RAM_HIT, SRAM_HIT, CARD_HIT,
                          (boot_seg & ~CPU_WR) | w0 | w1);

  // Cycle registers
  reg [3:0]  st_reg;
  reg [3:0]  st_next;
  reg [2:0]  cls_reg;
  reg        io_reg, wr_reg, word_reg, intr_reg;
  reg [1:0]  rom_reg;          // Chip enables to assert, active high
  reg        split_reg;        // Word being done as two bytes
  reg        half_reg;         // 0 = low byte, 1 = high byte of split
  reg [23:0] addr_reg;
  reg [15:0] wd_reg;
  reg [3:0]  cnt_reg;

  // Width of target: ROM from strap, others from the chip-select pins
  wire wide = (cls_reg == `EBS_TGT_ROM) ? ~strap :
              io_reg ? ~iocs16n : ~mcs16n;
  wire odd_addr = addr_reg[0];
  // Combined ready: external OR internal requests for extension
  wire extend = ~chrdy | INT_NOT_READY;
  wire ext_target = (cls_reg == `EBS_TGT_IO) | (cls_reg == `EBS_TGT_EXPMEM) |
                    (cls_reg == `EBS_TGT_ROM);
  wire cnt_done = (cnt_reg == 4'h0);
  wire finish = (st_reg == S_END) & ~(split_reg & ~half_reg);
  // A narrow word is known to split before split_reg catches up at the tick
  wire split_now = split_reg | (word_reg & ~wide);

  assign CPU_READY = finish;
  assign CPU_WAIT  = (st_reg != S_IDLE) & ~finish;

  // Next state; strobes wait for a bus tick and the extend term to drop
  always @* begin
    case (st_reg)
      S_IDLE:  st_next = CPU_REQ ? S_SET : S_IDLE;
      S_SET:   st_next = xtick ? S_STRB : S_SET;
      S_STRB:  st_next = (cnt_done & ~extend) ? S_END : S_STRB;
      S_END:   st_next = (split_reg & ~half_reg) ? S_SET : S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  // Cycle sequencer
  always @(posedge MCLK) begin
    if (core_rst) begin
      st_reg    <= S_IDLE;
      cls_reg   <= `EBS_TGT_RAM;
      io_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      word_reg  <= 1'b0;
      intr_reg  <= 1'b0;
      rom_reg   <= 2'b00;
      split_reg <= 1'b0;
      half_reg  <= 1'b0;
      addr_reg  <= 24'h000000;
      wd_reg    <= 16'h0000;
      cnt_reg   <= 4'h0;
      CPU_RDATA <= 16'h0000;
    end else begin
      st_reg <= st_next;
      case (st_reg)
        S_IDLE: begin
          if (CPU_REQ) begin
            cls_reg  <= cls;
            io_reg   <= CPU_IO;
            wr_reg   <= CPU_WR;
            word_reg <= CPU_WORD;
            intr_reg <= INT_PERIPH_HIT;
            rom_reg  <= {w1, w0 | (boot_seg & ~CPU_WR)} & {2{~CPU_IO}};
            addr_reg <= CPU_ADDR;
            wd_reg   <= CPU_WDATA;
            half_reg <= 1'b0;
            split_reg <= 1'b0;
          end
        end
        S_SET: begin
          // Target width is sampled once its chip select has settled
          if (xtick) begin
            cnt_reg <= `EBS_STROBE_CYC;
            if (word_reg & ~wide & ~half_reg)
              split_reg <= 1'b1;
          end
        end
        S_STRB: begin
          if (!cnt_done)
            cnt_reg <= cnt_reg - 4'h1;
          if (cnt_done & ~extend & ~wr_reg) begin
            // Byte data always returns on the low lane when narrow
            if (split_reg & half_reg)
              CPU_RDATA[15:8] <= D_IN[7:0];
            else if (split_reg)
              CPU_RDATA[7:0]  <= D_IN[7:0];
            else if (~word_reg & odd_addr & ~wide)
              CPU_RDATA       <= {D_IN[7:0], D_IN[7:0]};
            else
              CPU_RDATA       <= D_IN;
          end
        end
        S_END: begin
          if (split_reg & ~half_reg) begin
            half_reg <= 1'b1;
            addr_reg <= addr_reg + 24'h000001;
          end
        end
        default: ;
      endcase
    end
  end

  // Pin drivers: strobes low only during the strobe phase
  always @(posedge MCLK) begin
    if (core_rst) begin
      A_OUT                   <= 24'h000000;
      D_OUT                   <= 16'h0000;
      D_OE_N                  <= 1'b1;
      TARGET_CLASS            <= `EBS_TGT_RAM;
      EXT_IO_READ_STROBE_N    <= 1'b1;
      EXT_IO_WRITE_STROBE_N   <= 1'b1;
      EXT_MEM_READ_STROBE_N   <= 1'b1;
      EXT_MEM_WRITE_STROBE_N  <= 1'b1;
      BOOT_ROM_CHIP_ENABLES_N <= 2'b11;
      BYTE_HIGH_ENABLE_N      <= 1'b1;
    end else begin
      A_OUT        <= addr_reg;
      TARGET_CLASS <= cls_reg;
      // Narrow targets get write data on the low lane
      if (split_reg & half_reg)
        D_OUT <= {wd_reg[15:8], wd_reg[15:8]};
      else if (odd_addr & ~word_reg)
        D_OUT <= {wd_reg[7:0], wd_reg[7:0]};
      else
        D_OUT <= wd_reg;
      D_OE_N <= ~(wr_reg & ext_target & (st_next == S_STRB | st_reg == S_STRB));
      if (st_next == S_STRB) begin
        EXT_IO_READ_STROBE_N  <= ~(io_reg & ~wr_reg &
                                   ~(IORD_SUPPRESS_INT & intr_reg));
        EXT_IO_WRITE_STROBE_N <= ~(io_reg & wr_reg &
                                   ~(IOWR_SUPPRESS_INT & intr_reg));
        // Never for RAM; for ROM only when configured as its OE
        EXT_MEM_READ_STROBE_N <= ~(~io_reg & ~wr_reg &
                                   ((cls_reg == `EBS_TGT_EXPMEM) |
                                    ((cls_reg == `EBS_TGT_ROM) &
                                     MEM_RD_AS_ROM_OE)));
        EXT_MEM_WRITE_STROBE_N <= ~(wr_reg &
                                    (cls_reg == `EBS_TGT_EXPMEM));
        BOOT_ROM_CHIP_ENABLES_N <= (cls_reg == `EBS_TGT_ROM) ?
                                   ~rom_reg : 2'b11;
        // High lane used by a wide word, an odd byte to a wide target
        BYTE_HIGH_ENABLE_N <= ~((word_reg & ~split_now) |
                                (odd_addr & ~split_now & wide));
      end else begin
        EXT_IO_READ_STROBE_N    <= 1'b1;
        EXT_IO_WRITE_STROBE_N   <= 1'b1;
        EXT_MEM_READ_STROBE_N   <= 1'b1;
        EXT_MEM_WRITE_STROBE_N  <= 1'b1;
        BOOT_ROM_CHIP_ENABLES_N <= 2'b11;
        BYTE_HIGH_ENABLE_N      <= 1'b1;
      end
    end
  end
endmodule

//--- shared/ebs_defs.vh
// Constants for the external bus strobe steering block
`ifndef EBS_DEFS_VH
`define EBS_DEFS_VH
// Target classes decoded per cycle
`define EBS_TGT_RAM      3'h0
`define EBS_TGT_SRAM     3'h1
`define EBS_TGT_CARD     3'h2
`define EBS_TGT_ROM      3'h3
`define EBS_TGT_IO       3'h4
`define EBS_TGT_EXPMEM   3'h5
// Boot segment F000:0..FFFF:F in a 24-bit space (top nibble of 20-bit address)
`define EBS_BOOT_SEG_HI  4'hf
// Window map fields: 16 KB windows selected by address bits 19:14
`define EBS_WIN_LSB      14
`define EBS_WIN_MSB      19
// Expansion clock: 100 MHz / 12 = 8.33 MHz, toggle every 6 cycles
`define EBS_CLK_HZ       100000000
`define EBS_XCLK_HZ      8000000
`define EBS_XCLK_HALF    ((`EBS_CLK_HZ / `EBS_XCLK_HZ) / 2)
// Strobe counter load (pulse lasts one cycle longer) and reset stretch length
`define EBS_STROBE_CYC   4'h3
`define EBS_RST_STRETCH  8'h10
`endif
